/* rtl/sps_standby_power_sequencer.sv */
// Standby power sequencer: button debounce, shutdown sequence, supply request
`include "sps_defs.svh"
module sps_standby_power_sequencer #(
    parameter int unsigned DEBOUNCE_CYC = `SPS_DEBOUNCE_CYC,
    parameter int unsigned READY_CYC    = `SPS_READY_CYC,
    parameter int unsigned WAKE_CYC     = `SPS_CNT_W'(`SPS_WAKE_CYC)
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                power_toggle_button_n,
    input  wire logic                power_mode_command,
    input  wire logic                supply_switch_fitted,
    input  wire sps_pkg::sps_sw_ack_s sw_ack,
    output logic                     supply_on_request,
    output logic                     module_operating,
    output sps_pkg::sps_sw_req_s     sw_req,
    output logic                     button_pullup_en
);
    import sps_pkg::*;

    logic                   btn_meta_reg;
    logic                   btn_sync_reg;
    logic [`SPS_CNT_W-1:0]  deb_cnt_reg, deb_cnt_next;
    logic                   deb_armed_reg, deb_armed_next;
    logic                   toggle_reg, toggle_next;
    sps_state_e             state_reg, state_next;
    logic [`SPS_CNT_W-1:0]  tmr_reg, tmr_next;
    logic                   from_button_reg, from_button_next;
    logic                   supply_reg, supply_next;
    logic                   ready_reg, ready_next;
    sps_sw_req_s            req_reg, req_next;

    // Two-flop synchroniser on the pin; only the second flop is read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            btn_meta_reg <= 1'h1;
            btn_sync_reg <= 1'h1;
        end else begin
            btn_meta_reg <= power_toggle_button_n;
            btn_sync_reg <= btn_meta_reg;
        end
    end

    // Debounce: one toggle per press, re-armed only once the button is released
    always_comb begin
        deb_cnt_next   = deb_cnt_reg;
        deb_armed_next = deb_armed_reg;
        toggle_next    = 1'h0;
        if (btn_sync_reg) begin
            deb_cnt_next   = '0;
            deb_armed_next = 1'h1;
        end else if (deb_armed_reg) begin
            if (deb_cnt_reg >= `SPS_CNT_W'(DEBOUNCE_CYC - 1)) begin
                toggle_next    = 1'h1;
                deb_armed_next = 1'h0;
                deb_cnt_next   = '0;
            end else begin
                deb_cnt_next = deb_cnt_reg + `SPS_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            deb_cnt_reg   <= '0;
            deb_armed_reg <= 1'h0;        // A button held through reset still gives a toggle: the synchroniser resets high, which arms the debounce
            toggle_reg    <= 1'h0;
        end else begin
            deb_cnt_reg   <= deb_cnt_next;
            deb_armed_reg <= deb_armed_next;
            toggle_reg    <= toggle_next;
        end
    end

    // Power state sequencing
    always_comb begin
        state_next       = state_reg;
        tmr_next         = tmr_reg;
        from_button_next = from_button_reg;
        supply_next      = supply_reg;
        ready_next       = 1'h0;
        req_next         = '0;
        case (state_reg)
            SPS_OFF: begin
                state_next  = SPS_BOOT;
                supply_next = 1'h1;
                tmr_next    = '0;
            end
            SPS_BOOT: begin
                if (tmr_reg >= `SPS_CNT_W'(READY_CYC - 1)) begin
                    state_next = SPS_ACTIVE;
                    ready_next = 1'h1;
                end else begin
                    tmr_next = tmr_reg + `SPS_CNT_W'(1);
                end
            end
            SPS_ACTIVE: begin
                ready_next = 1'h1;
                if (toggle_reg || power_mode_command) begin
                    state_next       = SPS_SHUTDOWN;
                    from_button_next = toggle_reg;
                    ready_next       = 1'h0;
                    req_next         = '{stop_tasks: 1'h1, detach_card: 1'h1};
                end
            end
            SPS_SHUTDOWN: begin
                // Supply stays on until software confirms both steps
                req_next = '{stop_tasks: 1'h1, detach_card: 1'h1};
                if (sw_ack.tasks_stopped && sw_ack.card_detached) begin
                    req_next = '0;
                    tmr_next = '0;
                    if (!supply_switch_fitted && from_button_reg) begin
                        state_next = SPS_DOZE;
                    end else begin
                        state_next  = SPS_STANDBY;
                        supply_next = 1'h0;
                    end
                end
            end
            SPS_STANDBY: begin
                if (toggle_reg) begin
                    state_next  = SPS_BOOT;
                    supply_next = 1'h1;
                    tmr_next    = '0;
                end
            end
            SPS_DOZE: begin
                // Main supply never drops here, so either the button or a timed wake returns to boot
                if (toggle_reg || tmr_reg >= `SPS_CNT_W'(WAKE_CYC - 1)) begin
                    state_next = SPS_BOOT;
                    tmr_next   = '0;
                end else begin
                    tmr_next = tmr_reg + `SPS_CNT_W'(1);
                end
            end
            default: begin
                state_next  = SPS_OFF;
                supply_next = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg       <= SPS_OFF;
            tmr_reg         <= '0;
            from_button_reg <= 1'h0;
            supply_reg      <= 1'h0;
            ready_reg       <= 1'h0;
            req_reg         <= '0;
        end else begin
            state_reg       <= state_next;
            tmr_reg         <= tmr_next;
            from_button_reg <= from_button_next;
            supply_reg      <= supply_next;
            ready_reg       <= ready_next;
            req_reg         <= req_next;
        end
    end

    // Outputs straight from flops, pull-up enable tied high; the switch follows supply request on its own
    assign supply_on_request = supply_reg;
    assign module_operating  = ready_reg;
    assign sw_req            = req_reg;
    assign button_pullup_en  = 1'h1;

    // Assertions
    a_ready_only_active: assert property (@(posedge clk_sys) disable iff (rst)
        ready_reg |-> (state_reg == SPS_ACTIVE))
        else $error("operating status high outside active");
    a_ready_delay: assert property (@(posedge clk_sys) disable iff (rst)
        ($rose(ready_reg)) |-> ($past(tmr_reg) == `SPS_CNT_W'(READY_CYC - 1)))
        else $error("operating status rose at wrong time");
    a_supply_after_ack: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(supply_reg) |-> $past(sw_ack.tasks_stopped && sw_ack.card_detached))
        else $error("supply dropped before clean shutdown");
    a_shutdown_holds_supply: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == SPS_SHUTDOWN) |-> supply_reg)
        else $error("supply off during shutdown");
    a_cmd_starts_shutdown: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == SPS_ACTIVE && power_mode_command) |=> (state_reg == SPS_SHUTDOWN))
        else $error("standby command ignored");
    a_toggle_starts_shutdown: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == SPS_ACTIVE && toggle_reg) |=> req_reg.stop_tasks && req_reg.detach_card)
        else $error("button standby ignored");
    a_wake_raises_supply: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == SPS_STANDBY && toggle_reg) |=> supply_reg && state_reg == SPS_BOOT)
        else $error("wake did not raise supply");
    a_toggle_single: assert property (@(posedge clk_sys) disable iff (rst)
        toggle_reg |=> !toggle_reg [*2])
        else $error("debounce toggled twice");
    a_toggle_count: assert property (@(posedge clk_sys) disable iff (rst)
        toggle_next |-> (!btn_sync_reg && deb_cnt_reg == `SPS_CNT_W'(DEBOUNCE_CYC - 1)))
        else $error("toggle before debounce time");
    a_doze_keeps_supply: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == SPS_DOZE) |-> supply_reg && !ready_reg)
        else $error("doze state lost supply");
    c_cmd_standby: cover property (@(posedge clk_sys) disable iff (rst)
        state_reg == SPS_SHUTDOWN ##[1:50] state_reg == SPS_STANDBY);
    c_button_wake: cover property (@(posedge clk_sys) disable iff (rst)
        state_reg == SPS_STANDBY && toggle_reg);
    c_doze_wake: cover property (@(posedge clk_sys) disable iff (rst)
        state_reg == SPS_DOZE ##1 state_reg == SPS_BOOT);
endmodule

/* common/sps_defs.svh */
// Timing constants for the standby power sequencer
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH
`define SPS_CLK_HZ        25000000
`define SPS_DEBOUNCE_MS   50
`define SPS_READY_MS      300
`define SPS_WAKE_S        120
`define SPS_DEBOUNCE_CYC  ((`SPS_CLK_HZ / 1000) * `SPS_DEBOUNCE_MS)
`define SPS_READY_CYC     ((`SPS_CLK_HZ / 1000) * `SPS_READY_MS)
`define SPS_WAKE_CYC      (64'(`SPS_CLK_HZ) * 64'(`SPS_WAKE_S))
`define SPS_CNT_W         32
`endif

/* common/sps_pkg.sv */
// Types shared by the standby power sequencer
package sps_pkg;
    typedef enum logic [5:0] {
        SPS_OFF      = 6'h01,
        SPS_BOOT     = 6'h02,
        SPS_ACTIVE   = 6'h04,
        SPS_SHUTDOWN = 6'h08,
        SPS_STANDBY  = 6'h10,
        SPS_DOZE     = 6'h20
    } sps_state_e;

    // Handshake with the software task manager
    typedef struct packed {
        logic tasks_stopped;
        logic card_detached;
    } sps_sw_ack_s;

    typedef struct packed {
        logic stop_tasks;
        logic detach_card;
    } sps_sw_req_s;
endpackage

/* test/sps_far_side.sv */
// Far-side model: bouncing push-button, external power switch, software acknowledger
module sps_far_side (
    input  wire logic                 clk_sys,
    input  wire logic                 press,
    input  wire logic                 bounce,
    input  wire logic [3:0]           ack_delay,
    input  wire logic                 button_pullup_en,
    input  wire logic                 supply_on_request,
    input  wire sps_pkg::sps_sw_req_s sw_req,
    output logic                      power_toggle_button_n,
    output logic                      main_supply,
    output sps_pkg::sps_sw_ack_s      sw_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    logic [3:0] wait_cnt = 4'h0;
    logic       chatter  = 1'b0;
    // Contact chatter flips every cycle so a bouncing press never looks stable
    always @(posedge clk_sys) chatter <= ~chatter;
    // A released pin rests at the pull-up level; without pull-up it reads as pressed
    assign power_toggle_button_n = (press && !(bounce && chatter)) ? 1'b0 : button_pullup_en;
    // The switch powers the main supply exactly while the request is high
    assign main_supply = supply_on_request;
    // Both confirmations rise together after a chosen delay, so slow software is exercised
    always @(posedge clk_sys) begin
        if (!(sw_req.stop_tasks && sw_req.detach_card)) begin
            wait_cnt <= 4'h0;
            sw_ack   <= 2'h0;
        end else if (wait_cnt == ack_delay) begin
            sw_ack <= 2'h3;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

/* test/standby_power_sequencer_tb_top.sv */
// Self-checking bench for the standby power sequencer
module standby_power_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    localparam int DEB = 8;
    localparam int RDY = 20;
    localparam int WAKE = 50;
    logic        clk_sys = 1'b0, rst = 1'b1, cmd = 1'b0, fitted = 1'b1;
    logic        press = 1'b0, bounce = 1'b0;
    logic [3:0]  ack_delay = 4'h3;
    logic [31:0] lfsr = 32'h3DF47538;
    logic        supply_on_request, module_operating, button_pullup_en, button_n, main_supply;
    sps_sw_req_s sw_req;
    sps_sw_ack_s sw_ack;
    logic [3:0]  exp_q[$];
    logic [3:0]  prev = 4'h0;
    logic [3:0]  seen;
    int          n_errors = 0;
    int          tests_run = 0;
    int          since = 0;
    int          boot_len = RDY;

    sps_standby_power_sequencer #(.DEBOUNCE_CYC(DEB), .READY_CYC(RDY), .WAKE_CYC(WAKE))
    sps_standby_power_sequencer_inst (.clk_sys(clk_sys), .rst(rst),
        .power_toggle_button_n(button_n), .power_mode_command(cmd),
        .supply_switch_fitted(fitted), .sw_ack(sw_ack), .supply_on_request(supply_on_request),
        .module_operating(module_operating), .sw_req(sw_req), .button_pullup_en(button_pullup_en));
    sps_far_side sps_far_side_inst (.clk_sys(clk_sys), .press(press), .bounce(bounce),
        .ack_delay(ack_delay), .button_pullup_en(button_pullup_en),
        .supply_on_request(supply_on_request), .sw_req(sw_req),
        .power_toggle_button_n(button_n), .main_supply(main_supply), .sw_ack(sw_ack));

    // 25 MHz clock
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic compare_vec(input logic [3:0] exp, input logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // Boot length in cycles, from the change to supply-only (supply rise, or request drop in doze) to operating status rise
    task automatic compare_len(input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected boot length at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Each output change takes the oldest note; a change with no note is itself a fault
    always @(negedge clk_sys) begin
        seen = {supply_on_request, module_operating, sw_req};
        since = since + 1;
        if (seen !== prev) begin
            if (exp_q.size() == 0) compare_vec(prev, seen);
            else compare_vec(exp_q.pop_front(), seen);
            if (prev == 4'h8 && seen == 4'hC) compare_len(16'(boot_len), 16'(since));
            prev = seen;
            since = 0;
        end
    end
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic expect_seq(input logic [3:0] a, input logic [3:0] b);
        exp_q.push_back(a);
        exp_q.push_back(b);
    endtask
    // Bounded wait for all notes, then a quiet spell so late extra changes are caught
    task automatic drain(input string name);
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) cycles(1);
        if (exp_q.size() != 0) begin
            n_errors++;
            end_of_test();
        end
        cycles(30);
        $display("test %s done, mismatches so far %0d", name, n_errors);
    endtask
    // Three cycles of chatter, then a steady press; long presses get a random extra
    task automatic push_button(input int hold);
        lfsr = lfsr_next(lfsr);
        ack_delay <= lfsr[3:0];
        press <= 1'b1;
        bounce <= 1'b1;
        cycles(3);
        bounce <= 1'b0;
        cycles(hold + (hold > DEB ? int'(lfsr[7:4]) : 0));
        press <= 1'b0;
        cycles(2);
    endtask
    task automatic pulse_cmd();
        cmd <= 1'b1;
        cycles(1);
        cmd <= 1'b0;
    endtask

    // Main sequence
    initial begin
        cycles(4);
        expect_seq(4'h8, 4'hC);
        rst <= 1'b0;
        drain("power_up");
        compare_vec(4'h1, {3'h0, button_pullup_en});
        for (int src = 0; src < 2; src++) begin
            expect_seq(4'hB, 4'h0);
            if (src == 0) pulse_cmd();
            else push_button(DEB + 4);
            drain("standby_entry");
            expect_seq(4'h8, 4'hC);
            push_button(DEB + 4);
            drain("wake");
        end
        expect_seq(4'hB, 4'h0);
        press <= 1'b1;
        cycles(120);
        press <= 1'b0;
        drain("held_button");
        expect_seq(4'h8, 4'hC);
        push_button(DEB + 4);
        drain("rewake");
        push_button(DEB - 4);
        drain("short_press");
        exp_q.push_back(4'h0);
        expect_seq(4'h8, 4'hC);
        rst <= 1'b1;
        cycles(2);
        rst <= 1'b0;
        cycles(3);
        pulse_cmd();
        drain("reset_and_refused_command");
        fitted <= 1'b0;
        boot_len = WAKE + RDY;
        exp_q.push_back(4'hB);
        expect_seq(4'h8, 4'hC);
        push_button(DEB + 4);
        drain("doze");
        expect_seq(4'hB, 4'h0);
        pulse_cmd();
        drain("command_without_switch");
        end_of_test();
    end
endmodule
